// ===== rtl/ctro_core.sv
// Purpose: transmit request latching, buffer selection and queue put index
// Assumes: bit engine signals are on clk_sys; bus_level 0 means dominant
// Notes: shift register snapshot is taken at the 2nd intermission sample
`timescale 1ns/1ns
module ctro_core #(
  parameter int NDED = 4,
  parameter int NQ = 4,
  parameter int IDW = 29
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic bit_sample,
  input wire logic bus_level,
  input wire logic eof_last,
  input wire logic arb_lost,
  input wire logic tx_ack,
  input wire logic rx_valid,
  input wire logic [1:0] rx_target,
  input wire logic [(NDED+NQ)*IDW-1:0] buf_id_flat,
  output logic [1:0] protocol_activity_state,
  output logic tx_start,
  output logic [IDW-1:0] tx_shift_id,
  output logic [$clog2(NDED+NQ)-1:0] tx_shift_index,
  output logic evt_wr,
  output logic [IDW-1:0] evt_id,
  output logic rx_dedicated_buffer_new_flag,
  output logic rx_fifo0_new_flag,
  output logic rx_fifo1_new_flag,
  output logic irq
);
  localparam int NB = NDED + NQ;
  localparam int IW = $clog2(NB);
  localparam int QW = $clog2(NQ);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // lowest set bit of the pending vector
  function automatic logic [IW-1:0] lowest_set(input logic [NB-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IW'(i);
      end
    end
    return r;
  endfunction : lowest_set

  // lowest clear bit of the queue part
  function automatic logic [QW-1:0] lowest_free(input logic [NQ-1:0] v);
    logic [QW-1:0] r;
    r = '0;
    for (int i = NQ - 1; i >= 0; i--) begin
      if (!v[i]) begin
        r = QW'(i);
      end
    end
    return r;
  endfunction : lowest_free

  ctro_pkg::ctro_state_e state, next_state;
  logic [1:0] ifs_cnt, next_ifs_cnt;
  logic from_rx, next_from_rx;
  logic loaded, next_loaded;
  logic [IDW-1:0] shift_id, next_shift_id;
  logic [IW-1:0] shift_idx, next_shift_idx;
  logic [IW-1:0] tx_idx, next_tx_idx;
  logic next_start;
  logic init, next_init;
  logic cce, next_cce;
  logic [NB-1:0] pending, next_pending;
  logic [ctro_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [ctro_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [31:0] next_rdata;
  logic next_evt_wr;
  logic [IDW-1:0] next_evt_id;
  logic [1:0] act;
  logic pend_any;
  logic [IW-1:0] low_idx;
  logic [IDW-1:0] low_id;
  logic [IDW-1:0] req_id;
  logic [QW-1:0] put_idx;
  logic q_full;
  logic ack_now;

  // selection and identifier lookup
  assign pend_any = |pending;
  assign low_idx = lowest_set(pending);
  assign low_id = buf_id_flat[low_idx*IDW +: IDW];
  assign req_id = buf_id_flat[tx_idx*IDW +: IDW];
  assign put_idx = lowest_free(pending[NB-1:NDED]); // [RL15] [RL14]
  assign q_full = &pending[NB-1:NDED];
  assign ack_now = tx_ack && (state == ctro_pkg::CTRO_TX);

  ////////////////////////////////////////////////////////////////////////////
  // protocol sequencer

  // next state of sequencer and shift register
  always_comb begin
    next_state = state;
    next_ifs_cnt = ifs_cnt;
    next_from_rx = from_rx;
    next_loaded = loaded;
    next_shift_id = shift_id;
    next_shift_idx = shift_idx;
    next_tx_idx = tx_idx;
    next_start = 1'b0;
    if (init) begin
      next_state = ctro_pkg::CTRO_IDLE;
      next_ifs_cnt = ctro_pkg::IFS_CNT_RST;
      next_loaded = 1'b0;
    end else begin
      case (state)
        ctro_pkg::CTRO_IDLE: begin
          if (pend_any) begin
            next_state = ctro_pkg::CTRO_TX;
            next_shift_id = low_id; // [RL11]
            next_shift_idx = low_idx;
            next_tx_idx = low_idx;
            next_start = 1'b1;
          end else if (bit_sample && !bus_level) begin
            next_state = ctro_pkg::CTRO_RX;
          end
        end
        ctro_pkg::CTRO_RX: begin
          if (eof_last) begin
            next_state = ctro_pkg::CTRO_IFS; // [RL7]
            next_ifs_cnt = ctro_pkg::IFS_CNT_RST;
            next_from_rx = 1'b1;
            next_loaded = 1'b0;
          end
        end
        ctro_pkg::CTRO_TX: begin
          if (eof_last) begin
            next_state = ctro_pkg::CTRO_IFS; // [RL7]
            next_ifs_cnt = ctro_pkg::IFS_CNT_RST;
            next_from_rx = 1'b0;
            next_loaded = 1'b0;
          end else if (arb_lost) begin
            next_state = ctro_pkg::CTRO_RX;
          end
        end
        ctro_pkg::CTRO_IFS: begin
          if (bit_sample) begin
            next_ifs_cnt = ifs_cnt + 2'h1;
            // snapshot at the 2nd bit; later requests miss it
            if (ifs_cnt == ctro_pkg::IFS_CNT_2ND && pend_any) begin
              next_shift_id = low_id; // [RL11] [RL12]
              next_shift_idx = low_idx;
              next_loaded = 1'b1;
            end
            if (ifs_cnt == ctro_pkg::IFS_CNT_3RD) begin
              next_ifs_cnt = ctro_pkg::IFS_CNT_RST;
              if (!bus_level) begin
                // dominant 3rd bit is start of frame
                if (pend_any) begin
                  next_state = ctro_pkg::CTRO_TX; // [RL2]
                  next_start = 1'b1;
                  if (loaded) begin
                    // snapshot goes out, ack must record that same buffer
                    next_tx_idx = shift_idx; // [RL5]
                  end else if (from_rx) begin
                    // receiver, no snapshot: stale id goes out, frame stays valid
                    next_tx_idx = low_idx;
                    next_shift_id = shift_id; // [RL1] [RL4]
                    next_shift_idx = shift_idx;
                  end else begin
                    // not receiver: no window, fresh load
                    next_tx_idx = low_idx; // [RL3]
                    next_shift_id = low_id;
                    next_shift_idx = low_idx;
                  end
                end else begin
                  next_state = ctro_pkg::CTRO_RX; // [RL2]
                end
              end else if (pend_any) begin
                next_state = ctro_pkg::CTRO_TX;
                next_shift_id = low_id; // [RL11]
                next_shift_idx = low_idx;
                next_tx_idx = low_idx;
                next_start = 1'b1;
              end else begin
                next_state = ctro_pkg::CTRO_IDLE;
              end
            end
          end
        end
        default: begin
          next_state = ctro_pkg::CTRO_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ctro_pkg::CTRO_IDLE;
      ifs_cnt <= ctro_pkg::IFS_CNT_RST;
      from_rx <= 1'b0;
      loaded <= 1'b0;
      shift_id <= '0;
      shift_idx <= '0;
      tx_idx <= '0;
      tx_start <= 1'b0;
    end else begin
      state <= next_state;
      ifs_cnt <= next_ifs_cnt;
      from_rx <= next_from_rx;
      loaded <= next_loaded;
      shift_id <= next_shift_id;
      shift_idx <= next_shift_idx;
      tx_idx <= next_tx_idx;
      tx_start <= next_start;
    end
  end

  // activity encoding, receiver role kept through intermission
  always_comb begin
    if (init) begin
      act = ctro_pkg::ACT_SYNC;
    end else if (state == ctro_pkg::CTRO_RX) begin
      act = ctro_pkg::ACT_RX; // [RL3]
    end else if (state == ctro_pkg::CTRO_TX) begin
      act = ctro_pkg::ACT_TX;
    end else if (state == ctro_pkg::CTRO_IFS) begin
      act = from_rx ? ctro_pkg::ACT_RX : ctro_pkg::ACT_TX; // [RL3]
    end else begin
      act = ctro_pkg::ACT_IDLE;
    end
  end

  assign protocol_activity_state = act;
  assign tx_shift_id = shift_id;
  assign tx_shift_index = shift_idx;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  // next values of software-visible state
  always_comb begin
    logic [NB-1:0] set_v;
    logic [NB-1:0] clr_v;
    logic [ctro_pkg::IRQ_W-1:0] ev;
    set_v = '0;
    clr_v = '0;
    ev = '0;
    next_init = init;
    next_cce = cce;
    next_irq_mask = irq_mask;
    next_rdata = 32'h0000_0000;
    next_evt_wr = 1'b0;
    next_evt_id = evt_id;
    // acknowledged frame: record the requested buffer id
    if (ack_now) begin
      clr_v[tx_idx] = 1'b1;
      next_evt_wr = 1'b1;
      next_evt_id = req_id; // [RL5]
      ev[ctro_pkg::IRQ_TXD] = 1'b1;
    end
    // new-message flags at the last end-of-frame bit
    if (eof_last && rx_valid && !init) begin
      ev[ctro_pkg::IRQ_DRX] = (rx_target == ctro_pkg::TGT_DED); // [RL6]
      ev[ctro_pkg::IRQ_F0] = (rx_target == ctro_pkg::TGT_F0); // [RL6]
      ev[ctro_pkg::IRQ_F1] = (rx_target == ctro_pkg::TGT_F1); // [RL6]
    end
    next_irq_stat = irq_stat | ev;
    if (reg_wr) begin
      if (reg_addr == ctro_pkg::OFS_CTRL) begin
        next_init = reg_wdata[ctro_pkg::CTRL_INIT_BIT];
        // change enable only sticks while init stays set
        next_cce = reg_wdata[ctro_pkg::CTRL_INIT_BIT] &&
                   reg_wdata[ctro_pkg::CTRL_CCE_BIT]; // [RL10]
      end else if (reg_addr == ctro_pkg::OFS_ADD_REQ) begin
        if (!cce) begin
          set_v = reg_wdata[NB-1:0]; // [RL17] [RL13]
        end
      end else if (reg_addr == ctro_pkg::OFS_QUEUE_ADD) begin
        if (!cce && !q_full) begin
          set_v[IW'(NDED) + IW'(put_idx)] = 1'b1; // [RL15] [RL14]
        end
      end else if (reg_addr == ctro_pkg::OFS_IRQ_STAT) begin
        // write one clears, a new event wins
        next_irq_stat = (irq_stat & ~reg_wdata[ctro_pkg::IRQ_W-1:0]) | ev;
      end else if (reg_addr == ctro_pkg::OFS_IRQ_MASK) begin
        next_irq_mask = reg_wdata[ctro_pkg::IRQ_W-1:0];
      end
    end
    next_pending = (pending & ~clr_v) | set_v; // [RL17]
    if (reg_rd) begin
      if (reg_addr == ctro_pkg::OFS_CTRL) begin
        next_rdata[ctro_pkg::CTRL_INIT_BIT] = init;
        next_rdata[ctro_pkg::CTRL_CCE_BIT] = cce;
      end else if (reg_addr == ctro_pkg::OFS_STATUS) begin
        next_rdata[ctro_pkg::STAT_ACT_LSB +: 2] = act;
        next_rdata[ctro_pkg::STAT_PUT_LSB +: QW] = put_idx;
        next_rdata[ctro_pkg::STAT_QFULL_BIT] = q_full;
      end else if (reg_addr == ctro_pkg::OFS_PENDING) begin
        next_rdata[NB-1:0] = pending;
      end else if (reg_addr == ctro_pkg::OFS_IRQ_STAT) begin
        next_rdata[ctro_pkg::IRQ_W-1:0] = irq_stat;
      end else if (reg_addr == ctro_pkg::OFS_IRQ_MASK) begin
        next_rdata[ctro_pkg::IRQ_W-1:0] = irq_mask;
      end
    end
  end

  // register file registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      init <= ctro_pkg::RST_INIT;
      cce <= ctro_pkg::RST_CCE;
      pending <= '0;
      irq_stat <= '0;
      irq_mask <= '0;
      reg_rdata <= 32'h0000_0000;
      evt_wr <= 1'b0;
      evt_id <= '0;
    end else begin
      init <= next_init;
      cce <= next_cce;
      pending <= next_pending;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_rdata;
      evt_wr <= next_evt_wr;
      evt_id <= next_evt_id;
    end
  end

  // flags and interrupt
  assign rx_dedicated_buffer_new_flag = irq_stat[ctro_pkg::IRQ_DRX];
  assign rx_fifo0_new_flag = irq_stat[ctro_pkg::IRQ_F0];
  assign rx_fifo1_new_flag = irq_stat[ctro_pkg::IRQ_F1];
  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  stale_shift_a: assert property ( // [RL1]
    (state == ctro_pkg::CTRO_IFS && bit_sample && ifs_cnt == ctro_pkg::IFS_CNT_3RD &&
     !bus_level && pend_any && !loaded && from_rx && !init) |=>
      (tx_start && $stable(shift_id)))
    else $error("stale shift id not kept");
  loaded_idx_a: assert property ( // [RL5]
    (state == ctro_pkg::CTRO_IFS && bit_sample && ifs_cnt == ctro_pkg::IFS_CNT_3RD &&
     !bus_level && pend_any && loaded && !init) |=> (tx_idx == shift_idx))
    else $error("sent buffer not the acknowledged one");
  sof_third_a: assert property ( // [RL2]
    (state == ctro_pkg::CTRO_IFS && bit_sample && ifs_cnt == ctro_pkg::IFS_CNT_3RD &&
     !bus_level && !init) |=> (state == ctro_pkg::CTRO_TX || state == ctro_pkg::CTRO_RX))
    else $error("dominant third bit not start of frame");
  act_recv_a: assert property ( // [RL3]
    (state == ctro_pkg::CTRO_RX && !init) |-> (protocol_activity_state == ctro_pkg::ACT_RX))
    else $error("receiver state misreported");
  event_id_a: assert property ( // [RL5]
    ack_now |=> (evt_wr && evt_id == $past(req_id)))
    else $error("event id not requested id");
  rx_flag_a: assert property ( // [RL6]
    (eof_last && rx_valid && rx_target == ctro_pkg::TGT_F0 && !init) |=> rx_fifo0_new_flag)
    else $error("fifo0 new flag missing");
  ifs_hold_a: assert property ( // [RL7]
    (eof_last && state == ctro_pkg::CTRO_RX && !init) |=>
      (state == ctro_pkg::CTRO_IFS)[*2] ##0 (ifs_cnt == ctro_pkg::IFS_CNT_RST || bit_sample))
    else $error("intermission cut short");
  lowest_first_a: assert property ( // [RL11]
    (state == ctro_pkg::CTRO_IFS && bit_sample && ifs_cnt == ctro_pkg::IFS_CNT_2ND &&
     pend_any && !init) |=> (shift_idx == $past(low_idx) && loaded))
    else $error("snapshot not lowest pending");
  put_lowest_a: assert property ( // [RL15]
    (reg_wr && reg_addr == ctro_pkg::OFS_QUEUE_ADD && !cce && !q_full) |=>
      pending[IW'(NDED) + IW'($past(put_idx))])
    else $error("queue add missed put buffer");
  add_req_a: assert property ( // [RL17]
    (reg_wr && reg_addr == ctro_pkg::OFS_ADD_REQ && !cce) |=>
      ((pending & $past(reg_wdata[NB-1:0])) == $past(reg_wdata[NB-1:0])))
    else $error("add request bits not pending");
endmodule : ctro_core

// ===== pkg/ctro_pkg.sv
// Purpose: constants for the transmit request ordering block of a CAN FD controller
// Assumes: one clock clk_sys, synchronous active-high reset, 32-bit register port
// Notes: register offsets are byte addresses of aligned words
// Operation
// [RL1] A request raised between the 2nd and 3rd intermission sample, in receiver state with nothing pending, can start a frame with a stale identifier.
// [RL2] A dominant sample on the 3rd intermission bit counts as start of frame.
// [RL3] The activity field reads 10 in receiver state, the only state with the window.
// [RL4] A stale-identifier frame runs as a normal frame and raises no error.
// [RL5] On acknowledge the event record carries the requested buffer's identifier.
// [RL6] The three new-message flags are set at the last end-of-frame bit of an accepted frame.
// [RL7] Three intermission bits follow the last end-of-frame bit.
// [RL8] Software requests only while something is pending or not receiving, else waits 3 bit times after the receive flag.
// [RL9] Software may keep two or more lowest-priority empty filler frames pending.
// [RL10] Software clears the change-enable bit and requests before first leaving init.
// [RL11] Pending same-identifier buffers go out lowest buffer number first.
// [RL12] Requests raised one by one with gaps may go out of buffer-number order.
// [RL13] Software loads same-identifier messages first and requests them in one write.
// [RL14] Queue buffers with one identifier go out in the order of the buffers they landed in.
// [RL15] The queue put index points at the lowest-numbered free queue buffer.
// [RL16] Software uses a FIFO, ordered requests, one write or one reused buffer for order.
// [RL17] Each add-request bit written as one marks its buffer pending, all in one access.
package ctro_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ADD_REQ = 8'h08;
  localparam logic [7:0] OFS_PENDING = 8'h0C;
  localparam logic [7:0] OFS_QUEUE_ADD = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_CCE_BIT = 1;
  localparam int STAT_ACT_LSB = 0;
  localparam int STAT_PUT_LSB = 8;
  localparam int STAT_QFULL_BIT = 12;
  localparam int IRQ_W = 4;
  localparam int IRQ_DRX = 0;
  localparam int IRQ_F0 = 1;
  localparam int IRQ_F1 = 2;
  localparam int IRQ_TXD = 3;
  localparam logic [1:0] TGT_DED = 2'h0;
  localparam logic [1:0] TGT_F0 = 2'h1;
  localparam logic [1:0] TGT_F1 = 2'h2;
  localparam logic [1:0] ACT_SYNC = 2'h0;
  localparam logic [1:0] ACT_IDLE = 2'h1;
  localparam logic [1:0] ACT_RX = 2'h2;
  localparam logic [1:0] ACT_TX = 2'h3;
  localparam logic [1:0] IFS_CNT_RST = 2'h0;
  localparam logic [1:0] IFS_CNT_2ND = 2'h1;
  localparam logic [1:0] IFS_CNT_3RD = 2'h2;
  localparam logic RST_INIT = 1'b1;
  localparam logic RST_CCE = 1'b0;
  typedef enum logic [1:0] {
    CTRO_IDLE = 2'b00,
    CTRO_RX = 2'b01,
    CTRO_IFS = 2'b11,
    CTRO_TX = 2'b10
  } ctro_state_e;
endpackage : ctro_pkg

// ===== dv/ctro_bus_node.sv
// Purpose: far side of the controller: the bus bit engine and the other nodes
// Assumes: one clock clk_sys; all outputs change right after a rising edge
// Notes: bus level is only meaningful at a sample pulse; it toggles otherwise
`timescale 1ns/1ns
module ctro_bus_node (
  input wire logic clk_sys,
  output logic bit_sample,
  output logic bus_level,
  output logic eof_last,
  output logic arb_lost,
  output logic tx_ack,
  output logic rx_valid,
  output logic [1:0] rx_target
);
  logic junk;
  logic lvl;

  ////////////////////////////////////////////////////////////////////////////
  // level outside sample points is garbage so a stale value cannot pass
  assign bus_level = bit_sample ? lvl : junk;

  initial begin
    bit_sample = 1'b0;
    eof_last = 1'b0;
    arb_lost = 1'b0;
    tx_ack = 1'b0;
    rx_valid = 1'b0;
    rx_target = 2'h3;
    junk = 1'b0;
    lvl = 1'b1;
  end

  always @(posedge clk_sys) begin
    junk <= ~junk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one bit time: idle gap, then a sample pulse with level l
  task smp(input logic l);
    repeat (3) @(posedge clk_sys);
    bit_sample <= 1'b1;
    lvl <= l;
    @(posedge clk_sys);
    bit_sample <= 1'b0;
  endtask : smp

  // last end-of-frame bit, with acceptance and target of a received frame
  task eof(input logic v, input logic [1:0] t);
    @(posedge clk_sys);
    eof_last <= 1'b1;
    rx_valid <= v;
    rx_target <= t;
    @(posedge clk_sys);
    eof_last <= 1'b0;
    rx_valid <= 1'b0;
    rx_target <= 2'h3;
  endtask : eof

  // arbitration lost during the frame being sent
  task lose();
    @(posedge clk_sys);
    arb_lost <= 1'b1;
    @(posedge clk_sys);
    arb_lost <= 1'b0;
  endtask : lose

  // acknowledge of the frame being sent
  task ack();
    @(posedge clk_sys);
    tx_ack <= 1'b1;
    @(posedge clk_sys);
    tx_ack <= 1'b0;
  endtask : ack
endmodule : ctro_bus_node

// ===== dv/ctro_core_tb.sv
// Purpose: self-checking bench for request latching, ordering and put index
// Assumes: default sizes, 4 dedicated buffers and 4 queue buffers
// Notes: buffers 1 and 2 share one identifier
`timescale 1ns/1ns
module ctro_core_tb;
  typedef struct packed {logic v; logic [1:0] t; logic [31:0] stat;} ctro_row_s;
  logic clk_sys, rst, reg_wr, reg_rd, irq, tx_start, evt_wr;
  logic bit_sample, bus_level, eof_last, arb_lost, tx_ack, rx_valid;
  logic [1:0] rx_target, act;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8*29-1:0] buf_id_flat;
  logic [28:0] tx_shift_id, evt_id, cap_id, cap_evt;
  logic [2:0] tx_shift_index, cap_idx;
  int n_mismatch, tests_run, n_start, exp_start;
  ctro_row_s rows [5] = '{'{1'b1, 2'h0, 32'h1}, '{1'b1, 2'h1, 32'h2},
    '{1'b1, 2'h2, 32'h4}, '{1'b1, 2'h3, 32'h0}, '{1'b0, 2'h0, 32'h0}};

  ctro_core ctro_core_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_sample(bit_sample), .bus_level(bus_level), .eof_last(eof_last),
    .arb_lost(arb_lost), .tx_ack(tx_ack), .rx_valid(rx_valid), .rx_target(rx_target),
    .buf_id_flat(buf_id_flat), .protocol_activity_state(act), .tx_start(tx_start),
    .tx_shift_id(tx_shift_id), .tx_shift_index(tx_shift_index), .evt_wr(evt_wr),
    .evt_id(evt_id), .rx_dedicated_buffer_new_flag(), .rx_fifo0_new_flag(),
    .rx_fifo1_new_flag(), .irq(irq));

  ctro_bus_node ctro_bus_node_inst (.clk_sys(clk_sys), .bit_sample(bit_sample),
    .bus_level(bus_level), .eof_last(eof_last), .arb_lost(arb_lost), .tx_ack(tx_ack),
    .rx_valid(rx_valid), .rx_target(rx_target));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end

  // records what each start and each event record carried
  always @(posedge clk_sys) begin
    if (tx_start === 1'b1) begin
      n_start++;
      cap_id = tx_shift_id;
      cap_idx = tx_shift_index;
    end
    if (evt_wr === 1'b1) begin
      cap_evt = evt_id;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // three intermission bits, level of the third given
  task ifs3(input logic l3);
    ctro_bus_node_inst.smp(1'b1);
    ctro_bus_node_inst.smp(1'b1);
    ctro_bus_node_inst.smp(l3);
    repeat (3) @(posedge clk_sys);
  endtask : ifs3

  // acknowledge the running frame, end it and pass the intermission
  task next_frame(input logic l3);
    ctro_bus_node_inst.ack();
    ctro_bus_node_inst.eof(1'b0, 2'h3);
    ifs3(l3);
  endtask : next_frame

  task started(input logic [2:0] idx, input logic [28:0] id);
    exp_start++;
    chk(32'(n_start), 32'(exp_start));
    chk(32'(cap_idx), 32'(idx));
    chk(32'(cap_id), 32'(id));
  endtask : started

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    buf_id_flat = {29'h27, 29'h26, 29'h25, 29'h24, 29'h77, 29'h55, 29'h55, 29'h10};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values and refusals
    rd(ctro_pkg::OFS_CTRL, 32'h1);
    rd(ctro_pkg::OFS_STATUS, 32'h0);
    rd(ctro_pkg::OFS_PENDING, 32'h0);
    rd(ctro_pkg::OFS_IRQ_MASK, 32'h0);
    rd(ctro_pkg::OFS_ADD_REQ, 32'h0);
    rd(8'h1C, 32'h0);
    chk(32'(irq), 32'h0);
    wr(ctro_pkg::OFS_CTRL, 32'h3);
    wr(ctro_pkg::OFS_ADD_REQ, 32'h1);
    rd(ctro_pkg::OFS_PENDING, 32'h0);
    wr(ctro_pkg::OFS_CTRL, 32'h1);
    // queue fill in init, then leave init with requests pending
    wr(ctro_pkg::OFS_QUEUE_ADD, 32'h0);
    wr(ctro_pkg::OFS_QUEUE_ADD, 32'h0);
    rd(ctro_pkg::OFS_STATUS, 32'h200);
    wr(ctro_pkg::OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys);
    started(3'h4, 29'h24);
    rd(ctro_pkg::OFS_STATUS, 32'h203);
    ctro_bus_node_inst.ack();
    repeat (2) @(posedge clk_sys);
    chk(32'(cap_evt), 32'h24);
    rd(ctro_pkg::OFS_STATUS, 32'h003);
    ctro_bus_node_inst.eof(1'b0, 2'h3);
    ifs3(1'b1);
    started(3'h5, 29'h25);
    // same identifier in buffers 1 and 2, requested in one write
    wr(ctro_pkg::OFS_ADD_REQ, 32'h6);
    rd(ctro_pkg::OFS_PENDING, 32'h26);
    next_frame(1'b1);
    started(3'h1, 29'h55);
    next_frame(1'b1);
    started(3'h2, 29'h55);
    next_frame(1'b0);
    rd(ctro_pkg::OFS_STATUS, 32'h002);
    // new-message flags per receive target
    foreach (rows[i]) begin
      wr(ctro_pkg::OFS_IRQ_STAT, 32'hF);
      ctro_bus_node_inst.eof(rows[i].v, rows[i].t);
      rd(ctro_pkg::OFS_IRQ_STAT, rows[i].stat);
      ifs3(1'b0);
    end
    // interrupt raised, masked and cleared
    wr(ctro_pkg::OFS_IRQ_MASK, 32'h2);
    rd(ctro_pkg::OFS_IRQ_MASK, 32'h2);
    ctro_bus_node_inst.eof(1'b1, 2'h1);
    @(posedge clk_sys);
    #1;
    chk(32'(irq), 32'h1);
    wr(ctro_pkg::OFS_IRQ_STAT, 32'h2);
    #1;
    chk(32'(irq), 32'h0);
    ifs3(1'b0);
    // late request in the window: stale identifier goes out
    ctro_bus_node_inst.eof(1'b1, 2'h0);
    ctro_bus_node_inst.smp(1'b1);
    ctro_bus_node_inst.smp(1'b1);
    wr(ctro_pkg::OFS_ADD_REQ, 32'h8);
    ctro_bus_node_inst.smp(1'b0);
    repeat (3) @(posedge clk_sys);
    started(3'h2, 29'h55);
    ctro_bus_node_inst.ack();
    repeat (2) @(posedge clk_sys);
    chk(32'(cap_evt), 32'h77);
    rd(ctro_pkg::OFS_IRQ_STAT, 32'h9);
    chk(32'(irq), 32'h0);
    rd(ctro_pkg::OFS_PENDING, 32'h0);
    // same late request after an own frame: not receiver, fresh id
    ctro_bus_node_inst.eof(1'b0, 2'h3);
    ctro_bus_node_inst.smp(1'b1);
    ctro_bus_node_inst.smp(1'b1);
    wr(ctro_pkg::OFS_ADD_REQ, 32'h1);
    ctro_bus_node_inst.smp(1'b0);
    repeat (3) @(posedge clk_sys);
    started(3'h0, 29'h10);
    // filler kept pending closes the window for a late request
    wr(ctro_pkg::OFS_ADD_REQ, 32'h8);
    ctro_bus_node_inst.ack();
    repeat (2) @(posedge clk_sys);
    chk(32'(cap_evt), 32'h10);
    ctro_bus_node_inst.eof(1'b0, 2'h3);
    ifs3(1'b1);
    started(3'h3, 29'h77);
    ctro_bus_node_inst.lose();
    ctro_bus_node_inst.eof(1'b0, 2'h3);
    ctro_bus_node_inst.smp(1'b1);
    ctro_bus_node_inst.smp(1'b1);
    wr(ctro_pkg::OFS_ADD_REQ, 32'h1);
    ctro_bus_node_inst.smp(1'b0);
    repeat (3) @(posedge clk_sys);
    started(3'h3, 29'h77);
    ctro_bus_node_inst.ack();
    repeat (2) @(posedge clk_sys);
    chk(32'(cap_evt), 32'h77);
    rd(ctro_pkg::OFS_PENDING, 32'h1);
    final_report();
  end
endmodule : ctro_core_tb
